// *** fpec_host.sv ***
/*
 * Controller end: AXI4-Lite registers for raw accesses and ordered mode
 * entry sequences, driving the peripheral bus one request at a time.
 * Assumes the device answers every request with one ack pulse.
 */
`timescale 1ns/1ps
module fpec_host (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    fpec_if.host bus,
    input wire logic [4:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [4:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    import fpec_pkg::*;

    typedef enum logic [1:0] {H_IDLE, H_ISSUE, H_WAIT} fpec_hst_t;

    function automatic logic [31:0] strb(input logic [31:0] old, input logic [31:0] nw, input logic [3:0] s);
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                old[i*8 +: 8] = nw[i*8 +: 8];
            end
        end
        return old;
    endfunction

    // One step of an entry sequence: {last, byte}
    function automatic logic [8:0] seq_step(input fpec_op_t op, input logic [1:0] idx);
        logic [7:0] b;
        logic lst;
        b = SEQ_PERMIT;
        lst = 1'b1;
        if (idx != 2'h0) begin
            case (op)
                OP_PROG: b = (idx == 2'h1) ? SEQ_PSU : SEQ_PGO;
                OP_ERASE: b = (idx == 2'h1) ? SEQ_ESU : SEQ_EGO;
                OP_EVER: b = SEQ_EV;
                OP_PVER: b = SEQ_PV;
                default: b = SEQ_PERMIT;
            endcase
        end
        case (op)
            OP_PROG, OP_ERASE: lst = idx == 2'h2;
            OP_EVER, OP_PVER: lst = idx == 2'h1;
            default: lst = 1'b1;
        endcase
        return {lst, b};
    endfunction

    fpec_hst_t st_r;
    fpec_op_t op_r;
    logic [1:0] step_r;
    logic raw_wr_r;
    logic [1:0] raw_sz_r;
    logic [31:0] addr_r;
    logic [31:0] wdata_r;
    logic [31:0] rdata_r;
    logic err_r;
    logic req_r;
    logic bwr_r;
    logic [1:0] bsz_r;
    logic [31:0] baddr_r;
    logic [31:0] bwd_r;
    logic bvalid_r;
    logic [1:0] bresp_r;
    logic rvalid_r;
    logic [1:0] rresp_r;
    logic [31:0] axr_r;

    // ======================================
    // AXI decode
    wire wr_go = ce & s_axi_awvalid & s_axi_wvalid & !bvalid_r;
    wire rd_go = ce & s_axi_arvalid & !rvalid_r;
    wire busy = st_r != H_IDLE;
    wire w_ctrl = s_axi_awaddr == H_CTRL;
    wire w_addr = s_axi_awaddr == H_ADDR;
    wire w_wdat = s_axi_awaddr == H_WDATA;
    wire w_ok = (w_ctrl & !busy) | w_addr | w_wdat | (s_axi_awaddr == H_STAT) | (s_axi_awaddr == H_RDATA);
    wire start = wr_go & w_ctrl & !busy;
    wire [8:0] step = seq_step(op_r, step_r);
    wire is_raw = op_r == OP_RAW;
    wire [31:0] rsel = (s_axi_araddr == H_CTRL) ? {26'h0, raw_sz_r, raw_wr_r, op_r} :
        (s_axi_araddr == H_ADDR) ? addr_r :
        (s_axi_araddr == H_WDATA) ? wdata_r :
        (s_axi_araddr == H_STAT) ? {30'h0, err_r, busy} :
        (s_axi_araddr == H_RDATA) ? rdata_r : 32'h0;
    wire r_ok = (s_axi_araddr == H_CTRL) | (s_axi_araddr == H_ADDR) | (s_axi_araddr == H_WDATA) |
        (s_axi_araddr == H_STAT) | (s_axi_araddr == H_RDATA);

    // ======================================
    // AXI slave
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid_r <= 1'b0;
            bresp_r <= RESP_OKAY;
            rvalid_r <= 1'b0;
            rresp_r <= RESP_OKAY;
            axr_r <= 32'h0;
            addr_r <= 32'h0;
            wdata_r <= 32'h0;
        end else if (ce) begin
            if (wr_go) begin
                bvalid_r <= 1'b1;
                bresp_r <= w_ok ? RESP_OKAY : RESP_SLVERR;
                if (w_addr) begin
                    addr_r <= strb(addr_r, s_axi_wdata, s_axi_wstrb);
                end
                if (w_wdat) begin
                    wdata_r <= strb(wdata_r, s_axi_wdata, s_axi_wstrb);
                end
            end else if (s_axi_bready) begin
                bvalid_r <= 1'b0;
            end
            if (rd_go) begin
                rvalid_r <= 1'b1;
                axr_r <= rsel;
                rresp_r <= r_ok ? RESP_OKAY : RESP_SLVERR;
            end else if (s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ======================================
    // Sequencer: one device access per step
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= H_IDLE;
            op_r <= OP_RAW;
            step_r <= 2'h0;
            raw_wr_r <= 1'b0;
            raw_sz_r <= SZ_BYTE;
            rdata_r <= 32'h0;
            err_r <= 1'b0;
            req_r <= 1'b0;
            bwr_r <= 1'b0;
            bsz_r <= SZ_BYTE;
            baddr_r <= 32'h0;
            bwd_r <= 32'h0;
        end else if (ce) begin
            req_r <= 1'b0;
            case (st_r)
                H_IDLE: begin
                    if (start) begin
                        op_r <= fpec_op_t'(s_axi_wdata[2:0]);
                        raw_wr_r <= s_axi_wdata[3];
                        raw_sz_r <= s_axi_wdata[5:4];
                        step_r <= 2'h0;
                        err_r <= 1'b0;
                        st_r <= H_ISSUE;
                    end
                end
                H_ISSUE: begin
                    req_r <= 1'b1;
                    bwr_r <= is_raw ? raw_wr_r : 1'b1;
                    bsz_r <= is_raw ? raw_sz_r : SZ_BYTE;
                    baddr_r <= is_raw ? addr_r : FMC_ADDR;
                    bwd_r <= is_raw ? wdata_r : {24'h0, step[7:0]};
                    st_r <= H_WAIT;
                end
                H_WAIT: begin
                    if (bus.ack) begin
                        if (is_raw & !bwr_r) begin
                            rdata_r <= bus.rdata;
                        end
                        if (bus.err | is_raw | step[8]) begin
                            err_r <= bus.err;
                            st_r <= H_IDLE;
                        end else begin
                            step_r <= step_r + 2'h1;
                            st_r <= H_ISSUE;
                        end
                    end
                end
                default: st_r <= H_IDLE;
            endcase
        end
    end

    assign s_axi_awready = wr_go;
    assign s_axi_wready = wr_go;
    assign s_axi_bvalid = bvalid_r;
    assign s_axi_bresp = bresp_r;
    assign s_axi_arready = ce & !rvalid_r;
    assign s_axi_rvalid = rvalid_r;
    assign s_axi_rresp = rresp_r;
    assign s_axi_rdata = axr_r;
    assign bus.req = req_r;
    assign bus.wr = bwr_r;
    assign bus.size = bsz_r;
    assign bus.addr = baddr_r;
    assign bus.wdata = bwd_r;
endmodule

// *** fpec_pkg.sv ***
/*
 * Shared constants for the flash program/erase control block: register
 * addresses, field positions, access timing, sequence bytes, host map.
 * Assumes both ends and the bench import it whole.
 */
package fpec_pkg;
    // ======================================
    // Device register addresses
    localparam logic [31:0] FMC_ADDR = 32'hffffe800;
    localparam logic [31:0] FES_ADDR = 32'hffffe801;
    localparam logic [31:0] EBL_ADDR = 32'hffffe802;
    localparam logic [31:0] EBH_ADDR = 32'hffffe803;
    localparam logic [31:0] ROC_ADDR = 32'hffffec26;
    localparam logic [31:0] ROC_LO_ADDR = 32'hffffec27;
    // ======================================
    // Access sizes and timing
    localparam logic [1:0] SZ_BYTE = 2'h0;
    localparam logic [1:0] SZ_WORD = 2'h1;
    localparam logic [1:0] SZ_LONG = 2'h2;
    localparam logic [2:0] CYC_SHORT = 3'h3;
    localparam logic [2:0] CYC_LONG = 3'h6;
    // ======================================
    // Field positions and reset values
    localparam int SWP_BIT = 6;
    localparam int ESU_BIT = 5;
    localparam int PSU_BIT = 4;
    localparam int EV_BIT = 3;
    localparam int PV_BIT = 2;
    localparam int EGO_BIT = 1;
    localparam int PGO_BIT = 0;
    localparam logic [6:0] FMC_RST = 7'h00;
    localparam logic [7:0] EBL_RST = 8'h00;
    localparam logic [5:0] EBH_RST = 6'h00;
    localparam logic [3:0] ROC_RST = 4'h0;
    // ======================================
    // Mode entry byte sequences
    localparam logic [7:0] SEQ_PERMIT = 8'h40;
    localparam logic [7:0] SEQ_PSU = 8'h50;
    localparam logic [7:0] SEQ_PGO = 8'h51;
    localparam logic [7:0] SEQ_ESU = 8'h60;
    localparam logic [7:0] SEQ_EGO = 8'h62;
    localparam logic [7:0] SEQ_EV = 8'h48;
    localparam logic [7:0] SEQ_PV = 8'h44;
    typedef enum logic [2:0] {OP_RAW, OP_PROG, OP_ERASE, OP_EVER, OP_PVER, OP_EXIT} fpec_op_t;
    // ======================================
    // Host register map (AXI4-Lite)
    localparam logic [4:0] H_CTRL = 5'h00;
    localparam logic [4:0] H_ADDR = 5'h04;
    localparam logic [4:0] H_WDATA = 5'h08;
    localparam logic [4:0] H_STAT = 5'h0c;
    localparam logic [4:0] H_RDATA = 5'h10;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
endpackage

// *** fpec_if.sv ***
/*
 * Peripheral bus between the flash control registers and their controller.
 * Assumes one clock; the bench joins both ends through this interface.
 */
`timescale 1ns/1ps
interface fpec_if (
    input wire logic aclk
);
    logic req;
    logic wr;
    logic [1:0] size;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic ack;
    logic err;
    logic [31:0] rdata;
    modport dev (input req, input wr, input size, input addr, input wdata, output ack, output err, output rdata);
    modport host (output req, output wr, output size, output addr, output wdata, input ack, input err, input rdata);
endinterface

// *** fpec_dev.sv ***
/*
 * Flash mode control, error status, erase block select and RAM overlay
 * registers, write-permit gating of mode and erase block select, and bus access timing.
 * Assumes a controller that issues one request at a time and waits for ack.
 */
`timescale 1ns/1ps
module fpec_dev (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    fpec_if.dev bus,
    input wire logic flash_enabled,
    input wire logic hw_write_permit,
    input wire logic hw_standby,
    input wire logic sw_standby,
    input wire logic flash_error,
    output logic prog_setup,
    output logic erase_setup,
    output logic prog_mode,
    output logic erase_mode,
    output logic prog_verify,
    output logic erase_verify,
    output logic [13:0] erase_blocks,
    output logic [3:0] overlay_ctrl
);
    import fpec_pkg::*;

    typedef enum logic {S_IDLE, S_BUSY} fpec_st_t;

    function automatic logic multi_bit(input logic [13:0] v);
        return (v & (v - 14'h1)) != 14'h0;
    endfunction

    fpec_st_t st_r;
    logic [2:0] cnt_r;
    logic wr_r;
    logic [1:0] sz_r;
    logic [31:0] addr_r;
    logic [31:0] wd_r;
    logic ack_r;
    logic err_r;
    logic [31:0] rd_r;
    logic [6:0] fmc_r;
    logic [6:0] fmc_nxt;
    logic fes_r;
    logic [7:0] ebl_r;
    logic [7:0] ebl_nxt;
    logic [5:0] ebh_r;
    logic [5:0] ebh_nxt;
    logic [3:0] roc_r;
    logic [3:0] roc_nxt;

    // ======================================
    // Address decode
    wire is_fmc = addr_r == FMC_ADDR;
    wire is_fes = addr_r == FES_ADDR;
    wire is_ebl = addr_r == EBL_ADDR;
    wire is_ebh = addr_r == EBH_ADDR;
    wire is_roc = addr_r == ROC_ADDR;
    wire is_roc_lo = addr_r == ROC_LO_ADDR;
    wire byte_reg = is_fmc | is_fes | is_ebl | is_ebh;
    wire hit = byte_reg | is_roc | is_roc_lo;
    wire is_byte = sz_r == SZ_BYTE;
    wire size_ok = byte_reg ? is_byte : (is_roc | (is_roc_lo & is_byte));
    wire last = (st_r == S_BUSY) && (cnt_r == 3'h1);
    wire do_wr = last & wr_r & hit & size_ok & flash_enabled;
    wire [7:0] wb = wd_r[7:0];
    wire unlocked = hw_write_permit & fmc_r[SWP_BIT];
    wire clr_mode = hw_standby | sw_standby;

    // ======================================
    // Read data select
    wire [31:0] rsel = is_fmc ? {24'h0, hw_write_permit, fmc_r} :
        is_fes ? {24'h0, fes_r, 7'h0} :
        is_ebl ? {24'h0, ebl_r} :
        is_ebh ? {26'h0, ebh_r} :
        (is_roc & !is_byte) ? {28'h0, roc_r} :
        is_roc_lo ? {28'h0, roc_r} : 32'h0;
    wire [31:0] rval = (flash_enabled & size_ok) ? rsel : 32'h0;

    // ======================================
    // Register next values
    always_comb begin
        fmc_nxt = fmc_r;
        ebl_nxt = ebl_r;
        ebh_nxt = ebh_r;
        roc_nxt = roc_r;
        if (do_wr & is_fmc) begin
            fmc_nxt[SWP_BIT] = wb[SWP_BIT] & hw_write_permit;
            fmc_nxt[ESU_BIT] = wb[ESU_BIT] & unlocked;
            fmc_nxt[PSU_BIT] = wb[PSU_BIT] & unlocked;
            fmc_nxt[EV_BIT] = wb[EV_BIT] & unlocked;
            fmc_nxt[PV_BIT] = wb[PV_BIT] & unlocked;
            fmc_nxt[EGO_BIT] = wb[EGO_BIT] & unlocked & fmc_r[ESU_BIT];
            fmc_nxt[PGO_BIT] = wb[PGO_BIT] & unlocked & fmc_r[PSU_BIT];
        end
        if (do_wr & is_ebl & unlocked) begin
            ebl_nxt = wb;
        end
        if (do_wr & is_ebh & unlocked) begin
            ebh_nxt = wb[5:0];
        end
        if (multi_bit({ebh_nxt, ebl_nxt})) begin
            ebl_nxt = EBL_RST;
            ebh_nxt = EBH_RST;
        end
        if (do_wr & is_roc & !is_byte) begin
            roc_nxt = wd_r[3:0];
        end
        if (do_wr & is_roc_lo) begin
            roc_nxt = wb[3:0];
        end
        if (!hw_write_permit) begin
            fmc_nxt[SWP_BIT] = 1'b0;
        end
        if (!(hw_write_permit & fmc_nxt[SWP_BIT])) begin
            fmc_nxt[ESU_BIT:PGO_BIT] = FMC_RST[ESU_BIT:PGO_BIT];
            ebl_nxt = EBL_RST;
            ebh_nxt = EBH_RST;
        end
    end

    // ======================================
    // Bus access sequencer
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            st_r <= S_IDLE;
            cnt_r <= 3'h0;
            wr_r <= 1'b0;
            sz_r <= SZ_BYTE;
            addr_r <= 32'h0;
            wd_r <= 32'h0;
            ack_r <= 1'b0;
            err_r <= 1'b0;
            rd_r <= 32'h0;
        end else if (ce) begin
            ack_r <= 1'b0;
            case (st_r)
                S_IDLE: begin
                    if (bus.req) begin
                        wr_r <= bus.wr;
                        sz_r <= bus.size;
                        addr_r <= bus.addr;
                        wd_r <= bus.wdata;
                        cnt_r <= (bus.size == SZ_LONG) ? CYC_LONG - 3'h1 : CYC_SHORT - 3'h1;
                        st_r <= S_BUSY;
                    end
                end
                S_BUSY: begin
                    if (cnt_r == 3'h1) begin
                        ack_r <= 1'b1;
                        err_r <= !(hit & size_ok);
                        rd_r <= wr_r ? 32'h0 : rval;
                        st_r <= S_IDLE;
                    end else begin
                        cnt_r <= cnt_r - 3'h1;
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // ======================================
    // Register state
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            fmc_r <= FMC_RST;
            fes_r <= 1'b0;
            ebl_r <= EBL_RST;
            ebh_r <= EBH_RST;
            roc_r <= ROC_RST;
        end else if (ce) begin
            fmc_r <= clr_mode ? FMC_RST : fmc_nxt;
            ebl_r <= clr_mode ? EBL_RST : ebl_nxt;
            ebh_r <= clr_mode ? EBH_RST : ebh_nxt;
            roc_r <= hw_standby ? ROC_RST : roc_nxt;
            fes_r <= flash_error | (fes_r & !hw_standby);
        end
    end

    assign bus.ack = ack_r;
    assign bus.err = err_r;
    assign bus.rdata = rd_r;
    assign erase_setup = fmc_r[ESU_BIT];
    assign prog_setup = fmc_r[PSU_BIT];
    assign erase_verify = fmc_r[EV_BIT];
    assign prog_verify = fmc_r[PV_BIT];
    assign erase_mode = fmc_r[EGO_BIT];
    assign prog_mode = fmc_r[PGO_BIT];
    assign erase_blocks = {ebh_r, ebl_r};
    assign overlay_ctrl = roc_r;
endmodule

// *** fpec_props.sv ***
/* Timing checker for the peripheral bus between the flash control registers and their controller.
   Assumes it is instantiated beside the interface and sees its signals as plain inputs. */
`timescale 1ns/1ps
module fpec_props (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic req,
    input wire logic [1:0] size,
    input wire logic [31:0] addr,
    input wire logic ack,
    input wire logic err,
    input wire logic [31:0] rdata
);
    import fpec_pkg::*;
    // ==========================================
    // Decode and defaults
    wire byte_only = addr[31:2] == FMC_ADDR[31:2];
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);
    // ==========================================
    // Access timing
    property p_byte_time; req && size == SZ_BYTE |=> !ack [*2] ##1 ack; endproperty
    a_byte_time: assert property (p_byte_time)
        else $error("byte access not answered in three cycles");
    property p_word_time; req && size == SZ_WORD |=> !ack [*2] ##1 ack; endproperty
    a_word_time: assert property (p_word_time)
        else $error("word access not answered in three cycles");
    property p_long_time; req && size == SZ_LONG |=> !ack [*5] ##1 ack; endproperty
    a_long_time: assert property (p_long_time)
        else $error("long access not answered in six cycles");
    property p_ack_cause; ack |-> $past(req, 3) || $past(req, 6); endproperty
    a_ack_cause: assert property (p_ack_cause)
        else $error("answer without a matching request");
    property p_ack_pulse; ack |=> !ack; endproperty
    a_ack_pulse: assert property (p_ack_pulse)
        else $error("answer longer than one cycle");
    property p_hold; !ack && $past(aresetn) |-> $stable(rdata) && $stable(err); endproperty
    a_hold: assert property (p_hold)
        else $error("answer changed between answers");
    // ==========================================
    // Access size legality
    property p_byte_only; req && size == SZ_WORD && byte_only |-> ##3 (ack && err && rdata == 32'h0); endproperty
    a_byte_only: assert property (p_byte_only)
        else $error("word access to byte register not refused");
    property p_byte_ok; req && size == SZ_BYTE && byte_only |-> ##3 !err; endproperty
    a_byte_ok: assert property (p_byte_ok)
        else $error("byte access to byte register refused");
    property p_ovl_upper; req && size == SZ_BYTE && addr == ROC_ADDR |-> ##3 (!err && rdata == 32'h0); endproperty
    a_ovl_upper: assert property (p_ovl_upper)
        else $error("overlay upper byte not zero or refused");
    property p_long_ok; req && size == SZ_LONG && addr == ROC_ADDR |-> ##6 !err; endproperty
    a_long_ok: assert property (p_long_ok)
        else $error("long overlay access refused");
endmodule

// *** tb_top.sv ***
/* Self-checking bench joining both ends of the flash control block.
   Assumes the package, interface, both ends and the checker are compiled first. */
`timescale 1ns/1ps
module tb_top;
    import fpec_pkg::*;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic flash_enabled = 1'b1;
    logic hw_write_permit = 1'b1;
    logic hw_standby = 1'b0;
    logic sw_standby = 1'b0;
    logic flash_error = 1'b0;
    logic [4:0] awaddr = 5'h00;
    logic awvalid = 1'b0;
    logic [31:0] wdata = 32'h0;
    logic wvalid = 1'b0;
    logic [4:0] araddr = 5'h00;
    logic arvalid = 1'b0;
    wire awready, wready, bvalid, arready, rvalid;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [5:0] modes;
    wire [13:0] erase_blocks;
    wire [3:0] overlay_ctrl;
    int err_count = 0;
    int total_checks = 0;
    // ==========================================
    // Both ends and the checker
    fpec_if bus (.aclk(aclk));
    fpec_dev fpec_dev_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .bus(bus), .flash_enabled(flash_enabled),
        .hw_write_permit(hw_write_permit), .hw_standby(hw_standby), .sw_standby(sw_standby),
        .flash_error(flash_error), .prog_setup(modes[4]), .erase_setup(modes[5]), .prog_mode(modes[0]),
        .erase_mode(modes[1]), .prog_verify(modes[2]), .erase_verify(modes[3]), .erase_blocks(erase_blocks),
        .overlay_ctrl(overlay_ctrl));
    fpec_host fpec_host_inst (.aclk(aclk), .aresetn(aresetn), .ce(1'b1), .bus(bus), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf),
        .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
        .s_axi_bready(1'b1), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(1'b1));
    fpec_props fpec_props_inst (.aclk(aclk), .aresetn(aresetn), .req(bus.req), .size(bus.size),
        .addr(bus.addr), .ack(bus.ack), .err(bus.err), .rdata(bus.rdata));
    always #2 aclk = ~aclk;
    // ==========================================
    // Reporting and bus tasks
    task automatic complete_run;
        $display("checks %0d errors %0d", total_checks, err_count);
        if (err_count == 0 && total_checks > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("ERROR %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic hang(input int n);
        if (n >= 200) begin
            err_count++;
            $display("ERROR %0t: wait timed out", $time);
            complete_run();
        end
    endtask
    task automatic axi_wr(input logic [4:0] a, input logic [31:0] d);
        int n;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        n = 0;
        do @(posedge aclk) n++; while (awready !== 1'b1 && n < 200);
        hang(n);
        awvalid <= 1'b0;
        wvalid <= 1'b0;
        n = 0;
        do @(posedge aclk) n++; while (bvalid !== 1'b1 && n < 200);
        hang(n);
    endtask
    task automatic axi_rd(input logic [4:0] a, output logic [31:0] d);
        int n;
        araddr <= a;
        arvalid <= 1'b1;
        n = 0;
        do @(posedge aclk) n++; while (arready !== 1'b1 && n < 200);
        hang(n);
        arvalid <= 1'b0;
        n = 0;
        do @(posedge aclk) n++; while (rvalid !== 1'b1 && n < 200);
        hang(n);
        d = rdata;
    endtask
    task automatic wait_idle(output logic e);
        logic [31:0] s;
        int n;
        n = 0;
        do begin
            axi_rd(H_STAT, s);
            n++;
        end while (s[0] !== 1'b0 && n < 200);
        hang(n);
        e = s[1];
    endtask
    task automatic dev_acc(input logic [31:0] a, input logic [31:0] d, input logic [1:0] sz, input logic w,
                           output logic [31:0] rd, output logic e);
        axi_wr(H_ADDR, a);
        axi_wr(H_WDATA, d);
        axi_wr(H_CTRL, {26'h0, sz, w, 3'h0});
        wait_idle(e);
        axi_rd(H_RDATA, rd);
    endtask
    task automatic wrb(input logic [31:0] a, input logic [7:0] d);
        logic [31:0] r;
        logic e;
        dev_acc(a, {24'h0, d}, SZ_BYTE, 1'b1, r, e);
    endtask
    task automatic rdb(input logic [31:0] a, output logic [31:0] r);
        logic e;
        dev_acc(a, 32'h0, SZ_BYTE, 1'b0, r, e);
    endtask
    task automatic run_op(input fpec_op_t op);
        logic e;
        axi_wr(H_CTRL, {29'h0, op});
        wait_idle(e);
    endtask
    // ==========================================
    // Scenarios
    task automatic t_reset;
        logic [31:0] r;
        rdb(FMC_ADDR, r);
        check(r, 32'h80);
        rdb(EBL_ADDR, r);
        check(r, 32'h0);
        check({18'h0, erase_blocks}, 32'h0);
    endtask
    task automatic t_modes;
        logic [31:0] r;
        run_op(OP_PROG);
        check({26'h0, modes}, 32'h11);
        rdb(FMC_ADDR, r);
        check(r, 32'hd1);
        run_op(OP_EXIT);
        run_op(OP_ERASE);
        check({26'h0, modes}, 32'h22);
        rdb(FMC_ADDR, r);
        check(r, 32'he2);
        run_op(OP_EXIT);
        run_op(OP_EVER);
        check({26'h0, modes}, 32'h08);
        run_op(OP_EXIT);
        check({26'h0, modes}, 32'h0);
        run_op(OP_PVER);
        check({26'h0, modes}, 32'h04);
        run_op(OP_EXIT);
        check({26'h0, modes}, 32'h0);
    endtask
    task automatic t_gate;
        logic [31:0] r;
        wrb(FMC_ADDR, 8'h40); // Permit first, then go without its setup bit
        wrb(FMC_ADDR, 8'h41);
        rdb(FMC_ADDR, r);
        check(r, 32'hc0);
        wrb(FMC_ADDR, 8'h42);
        rdb(FMC_ADDR, r);
        check(r, 32'hc0);
        wrb(EBL_ADDR, 8'h04);
        check({18'h0, erase_blocks}, 32'h0004);
        wrb(EBL_ADDR, 8'h00);
        wrb(EBH_ADDR, 8'h20);
        check({18'h0, erase_blocks}, 32'h2000);
        hw_write_permit <= 1'b0;
        rdb(FMC_ADDR, r);
        check(r, 32'h00);
        check({18'h0, erase_blocks}, 32'h0);
        wrb(FMC_ADDR, 8'h40);
        rdb(FMC_ADDR, r);
        check(r, 32'h00);
        hw_write_permit <= 1'b1;
        wrb(FMC_ADDR, 8'h10);
        rdb(FMC_ADDR, r);
        check(r, 32'h80);
    endtask
    task automatic t_standby;
        logic [31:0] r;
        run_op(OP_PROG);
        sw_standby <= 1'b1;
        @(posedge aclk);
        sw_standby <= 1'b0;
        rdb(FMC_ADDR, r);
        check(r, 32'h80);
        run_op(OP_ERASE);
        hw_standby <= 1'b1;
        @(posedge aclk);
        hw_standby <= 1'b0;
        rdb(FMC_ADDR, r);
        check(r, 32'h80);
    endtask
    task automatic t_sizes;
        logic [31:0] r;
        logic e;
        dev_acc(FMC_ADDR, 32'h40, SZ_WORD, 1'b1, r, e);
        check({31'h0, e}, 32'h1);
        dev_acc(ROC_ADDR, 32'ha, SZ_LONG, 1'b1, r, e);
        check({28'h0, overlay_ctrl}, 32'ha);
        wrb(ROC_LO_ADDR, 8'h05);
        dev_acc(ROC_ADDR, 32'h0, SZ_WORD, 1'b0, r, e);
        check(r, 32'h5);
        rdb(ROC_ADDR, r);
        check(r, 32'h0);
    endtask
    task automatic t_disabled;
        logic [31:0] r;
        flash_enabled <= 1'b0;
        flash_error <= 1'b1;
        wrb(FMC_ADDR, 8'h40);
        rdb(FMC_ADDR, r);
        check(r, 32'h0);
        rdb(FES_ADDR, r);
        check(r, 32'h0);
        flash_enabled <= 1'b1;
        rdb(FMC_ADDR, r);
        check(r, 32'h80);
        rdb(FES_ADDR, r);
        check(r, 32'h80);
    endtask
    initial begin
        repeat (10) @(posedge aclk);
        aresetn <= 1'b1;
        t_reset();
        t_modes();
        t_gate();
        t_standby();
        t_sizes();
        t_disabled();
        complete_run();
    end
endmodule
